/* rtl/line_iface_pkg.sv */
// Package: register map, field layout and types of the line interface status block
package line_iface_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_PULSE_SHAPE = 16'h1001;
  localparam logic [15:0] IDX_MAINT_CTRL  = 16'h1002;
  localparam logic [15:0] IDX_LIVE_COND   = 16'h1003;
  localparam logic [15:0] IDX_IRQ_ENABLES = 16'h1004;
  localparam logic [15:0] IDX_EVENT_LATCH = 16'h1005;
  localparam logic [15:0] IDX_RX_LEVEL    = 16'h1006;
  localparam logic [15:0] IDX_LEVEL_CFG   = 16'h1010;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PULSE_SHAPE = 8'h00;
  localparam logic [7:0] RST_MAINT_CTRL  = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_EVENT_LATCH = 8'h00;
  localparam logic [7:0] RST_LEVEL_CFG   = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_TX_POWER_OFF   = 2;
  localparam int BIT_RX_POWER_OFF   = 1;
  localparam int BIT_LINE_DRIVER_ON = 0;
  localparam int BIT_SHORT_HAUL     = 0;
  localparam int BIT_T1_MODE        = 1;
  localparam int POS_GAIN_CAP       = 4;
  localparam int POS_LEVEL_CODE     = 4;
  localparam int BIT_SHORT_BEGAN    = 1;
  localparam int BIT_OPEN_BEGAN     = 2;

  // Pulse shape codes that select a T1 CSU shape
  localparam logic [2:0] SHAPE_CSU_FIRST = 3'h5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic jitter_trip;
    logic equalizer_over;
    logic equalizer_under;
    logic rx_short_now;
    logic tx_short_now;
    logic tx_open_now;
    logic signal_lost;
  } line_cond_t;

  localparam int COND_W = $bits(line_cond_t);

endpackage

/* rtl/cond_sync.sv */
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none
module cond_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          stage1[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* rtl/event_latch.sv */
// Sticky event bits, cleared by writing one, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module event_latch #(
  parameter int         WIDTH     = 8,
  parameter logic [7:0] RST_VALUE = 8'h00
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] set_vec,
  input  wire logic [WIDTH-1:0] clr_vec,
  output logic      [WIDTH-1:0] held
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          held[i] <= RST_VALUE[i];
        end else if (set_vec[i]) begin
          held[i] <= 1'b1;
        end else if (clr_vec[i]) begin
          held[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* rtl/line_iface_status_irq_regs.sv */
// Line interface control tail, live status, event latches and level code
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module line_iface_status_irq_regs #(
  parameter int ADDR_W = 16
) (
  input  wire logic              REF_CLK,
  input  wire logic              RESET,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              SIGNAL_LOST,
  input  wire logic              RX_SHORT_NOW,
  input  wire logic              TX_SHORT_NOW,
  input  wire logic              TX_OPEN_NOW,
  input  wire logic              EQUALIZER_OVER,
  input  wire logic              EQUALIZER_UNDER,
  input  wire logic              JITTER_TRIP,
  input  wire logic [3:0]        RX_LEVEL_RAW,
  input  wire logic              DRIVER_OVERRIDE_PIN,
  output logic                   TX_POWER_OFF,
  output logic                   RX_POWER_OFF,
  output logic                   TX_LINE_POS_OE,
  output logic                   TX_LINE_NEG_OE,
  output logic                   LINE_IRQ
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  line_iface_pkg::line_cond_t cond_raw;
  line_iface_pkg::line_cond_t cond;
  logic [3:0]                 level_s;
  logic                       pin_s;
  logic [line_iface_pkg::COND_W+4:0] sync_in;
  logic [line_iface_pkg::COND_W+4:0] sync_out;

  assign cond_raw.jitter_trip     = JITTER_TRIP;
  assign cond_raw.equalizer_over  = EQUALIZER_OVER;
  assign cond_raw.equalizer_under = EQUALIZER_UNDER;
  assign cond_raw.rx_short_now    = RX_SHORT_NOW;
  assign cond_raw.tx_short_now    = TX_SHORT_NOW;
  assign cond_raw.tx_open_now     = TX_OPEN_NOW;
  assign cond_raw.signal_lost     = SIGNAL_LOST;
  assign sync_in = {DRIVER_OVERRIDE_PIN, RX_LEVEL_RAW, cond_raw};

  cond_sync #(
    .WIDTH    (line_iface_pkg::COND_W + 5)
  ) u_sync (
    .clk      (REF_CLK),
    .rst      (RESET),
    .async_in (sync_in),
    .sync_out (sync_out)
  );

  assign cond    = sync_out[line_iface_pkg::COND_W-1:0];
  assign level_s = sync_out[line_iface_pkg::COND_W+3:line_iface_pkg::COND_W];
  assign pin_s   = sync_out[line_iface_pkg::COND_W+4];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [7:0] pulse_shape;
  logic [7:0] maint_ctrl;
  logic [7:0] irq_enables;
  logic [7:0] level_cfg;
  logic [7:0] latches;
  logic [7:0] live;
  logic [7:0] level_reg;

  wire [ADDR_W-1:0] idx      = {2'b00, PADDR[ADDR_W-1:2]};
  wire              setup    = PSEL && !PENABLE;
  wire              access   = PSEL && PENABLE;
  wire              hit_shp  = idx == ADDR_W'(line_iface_pkg::IDX_PULSE_SHAPE);
  wire              hit_ctl  = idx == ADDR_W'(line_iface_pkg::IDX_MAINT_CTRL);
  wire              hit_live = idx == ADDR_W'(line_iface_pkg::IDX_LIVE_COND);
  wire              hit_ien  = idx == ADDR_W'(line_iface_pkg::IDX_IRQ_ENABLES);
  wire              hit_lat  = idx == ADDR_W'(line_iface_pkg::IDX_EVENT_LATCH);
  wire              hit_lvl  = idx == ADDR_W'(line_iface_pkg::IDX_RX_LEVEL);
  wire              hit_cfg  = idx == ADDR_W'(line_iface_pkg::IDX_LEVEL_CFG);
  wire              aligned  = PADDR[1:0] == 2'b00;
  wire              mapped   = aligned && (hit_shp || hit_ctl || hit_live || hit_ien
                                           || hit_lat || hit_lvl || hit_cfg);
  wire              wr       = access && PWRITE && mapped;
  wire              wr_shp   = wr && hit_shp;
  wire              wr_ctl   = wr && hit_ctl;
  wire              wr_ien   = wr && hit_ien;
  wire              wr_lat   = wr && hit_lat;
  wire              wr_cfg   = wr && hit_cfg;

  // Zero-wait slave; unmapped or misaligned access flagged in access phase
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !mapped;

  // ----------------------------------------------------------------
  // Read mux, sampled in the setup phase
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    if (!aligned) begin
      next_rdata = 8'h00;
    end else if (hit_shp) begin
      next_rdata = pulse_shape;
    end else if (hit_ctl) begin
      next_rdata = maint_ctrl;
    end else if (hit_live) begin
      next_rdata = live;
    end else if (hit_ien) begin
      next_rdata = irq_enables;
    end else if (hit_lat) begin
      next_rdata = latches;
    end else if (hit_lvl) begin
      next_rdata = level_reg;
    end else if (hit_cfg) begin
      next_rdata = level_cfg;
    end else begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      PRDATA <= {24'h00_0000, next_rdata};
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pulse_shape <= line_iface_pkg::RST_PULSE_SHAPE;
      maint_ctrl  <= line_iface_pkg::RST_MAINT_CTRL;
      irq_enables <= line_iface_pkg::RST_IRQ_ENABLES;
      level_cfg   <= line_iface_pkg::RST_LEVEL_CFG;
    end else begin
      if (wr_shp) begin
        pulse_shape <= {5'h00, PWDATA[2:0]};
      end
      if (wr_ctl) begin
        maint_ctrl <= {5'h00, PWDATA[2:0]};
      end
      if (wr_ien) begin
        irq_enables <= PWDATA[7:0];
      end
      if (wr_cfg) begin
        level_cfg <= {PWDATA[7:4], 2'b00, PWDATA[1:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Power and driver control
  // ----------------------------------------------------------------
  wire tx_off    = maint_ctrl[line_iface_pkg::BIT_TX_POWER_OFF];
  wire rx_off    = maint_ctrl[line_iface_pkg::BIT_RX_POWER_OFF];
  wire driver_on = maint_ctrl[line_iface_pkg::BIT_LINE_DRIVER_ON];
  // Pin low forces high impedance whatever the driver-on bit says
  wire drive     = !tx_off && driver_on && pin_s;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      TX_POWER_OFF   <= 1'b0;
      RX_POWER_OFF   <= 1'b0;
      TX_LINE_POS_OE <= 1'b0;
      TX_LINE_NEG_OE <= 1'b0;
    end else begin
      TX_POWER_OFF   <= tx_off;
      RX_POWER_OFF   <= rx_off;
      TX_LINE_POS_OE <= drive;
      TX_LINE_NEG_OE <= drive;
    end
  end

  // ----------------------------------------------------------------
  // Live condition flags, no latching
  // ----------------------------------------------------------------
  assign live = {2'b00, cond.equalizer_over, cond.equalizer_under,
                 cond.rx_short_now, cond.tx_short_now,
                 cond.tx_open_now, cond.signal_lost};

  // ----------------------------------------------------------------
  // Event detection and latches
  // ----------------------------------------------------------------
  logic [3:0] prev;
  wire  [3:0] now = {cond.jitter_trip, cond.tx_open_now, cond.tx_short_now,
                     cond.signal_lost};
  wire  [3:0] rise = now & ~prev;
  wire  [3:0] fall = prev & ~now;
  wire        csu_shape = level_cfg[line_iface_pkg::BIT_T1_MODE]
                          && pulse_shape[2:0] >= line_iface_pkg::SHAPE_CSU_FIRST;
  // Open and short onset detectors are not valid under CSU shapes
  wire  [3:0] onset = rise & ~({2'b00, csu_shape, csu_shape} << 1);
  wire  [7:0] set_vec = {fall, onset};
  wire  [7:0] clr_vec = wr_lat ? PWDATA[7:0] : 8'h00;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      prev <= 4'h0;
    end else begin
      prev <= now;
    end
  end

  event_latch #(
    .WIDTH     (8),
    .RST_VALUE (line_iface_pkg::RST_EVENT_LATCH)
  ) u_latch (
    .clk       (REF_CLK),
    .rst       (RESET),
    .set_vec   (set_vec),
    .clr_vec   (clr_vec),
    .held      (latches)
  );

  wire irq_any = |(latches & irq_enables);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      LINE_IRQ <= 1'b0;
    end else begin
      LINE_IRQ <= irq_any;
    end
  end

  // ----------------------------------------------------------------
  // Receive level code
  // ----------------------------------------------------------------
  wire       short_haul = level_cfg[line_iface_pkg::BIT_SHORT_HAUL];
  wire [3:0] gain_cap   = level_cfg[line_iface_pkg::POS_GAIN_CAP +: 4];
  wire [3:0] level_code = (short_haul && level_s > gain_cap) ? gain_cap : level_s;

  assign level_reg = {level_code, 4'h0};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_tx_off_hiz: assert property (tx_off |=> !TX_LINE_POS_OE && !TX_LINE_NEG_OE)
    else $error("driver on while transmitter powered off");
  a_rx_off_write: assert property (wr_ctl |=> ##1 RX_POWER_OFF == $past(PWDATA[1], 2))
    else $error("receiver power-off not applied");
  a_pin_override: assert property (!pin_s |=> !TX_LINE_POS_OE)
    else $error("driver on while override pin low");
  a_driver_on: assert property (pin_s && driver_on && !tx_off |=> TX_LINE_NEG_OE)
    else $error("driver not enabled");
  a_live_los: assert property (SIGNAL_LOST [*3] |-> live[0])
    else $error("live loss flag missing");
  a_live_shorts: assert property (!RX_SHORT_NOW && TX_SHORT_NOW ##2 1 |-> live[3:2] == 2'b01)
    else $error("live short flags wrong");
  a_live_open: assert property (!TX_OPEN_NOW [*3] |-> !live[1])
    else $error("live open flag stuck");
  a_live_eq: assert property (EQUALIZER_OVER && !EQUALIZER_UNDER ##2 1 |-> live[5:4] == 2'b10)
    else $error("equalizer flags wrong");
  a_latch_hold: assert property (latches[0] && !clr_vec[0] |=> latches[0])
    else $error("latched bit lost");
  a_onset_sets: assert property (rise[0] |=> latches[0])
    else $error("onset not latched");
  a_onset_latch: assert property (rise[3] |=> latches[3])
    else $error("jitter onset not latched");
  a_removal_sets: assert property (fall[0] |=> latches[4])
    else $error("removal not latched");
  a_csu_quiet: assert property (csu_shape && !latches[2] && !wr_shp && !wr_cfg |=> !latches[2])
    else $error("open onset latched in CSU shape");
  a_level_low: assert property (setup && !PWRITE && hit_lvl && aligned |=> PRDATA[3:0] == 4'h0)
    else $error("level low bits not zero");
  a_level_cap: assert property (setup && !PWRITE && hit_lvl && aligned && short_haul
                                |=> PRDATA[7:4] <= $past(gain_cap))
    else $error("level code above cap");
  a_set_wins: assert property (set_vec[1] && clr_vec[1] |=> latches[1])
    else $error("clear beat a recurring event");
  a_clear_one: assert property (wr_lat && PWDATA[4] && !set_vec[4] |=> !latches[4])
    else $error("write one did not clear");
  a_irq_follow: assert property (irq_any |=> LINE_IRQ ##0 $past(irq_any))
    else $error("interrupt not raised");
  a_irq_drop: assert property (!irq_any |=> !LINE_IRQ)
    else $error("interrupt raised with nothing enabled");

endmodule
`default_nettype wire

/* sim/line_model.sv */
// Line-side model: detector levels and receive level presented to the block
`timescale 1ns/1ps
`default_nettype none
module line_model (
  input  wire logic                       clk,
  input  wire line_iface_pkg::line_cond_t want,
  input  wire logic [3:0]                 want_level,
  output var  line_iface_pkg::line_cond_t cond,
  output var  logic [3:0]                 level_raw
);
  // ----------------------------------------------------------------
  // Conditions change just after an edge, like a real detector output
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    cond      <= want;
    level_raw <= want_level;
  end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Register-level testbench of the line interface status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR %s exp %h got %h", what, (exp), (got)); end end
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                       clk = 1'b0;
  logic                       rst, psel, penable, pwrite, pin;
  logic [15:0]                paddr;
  logic [31:0]                pwdata, prdata;
  logic                       pready, pslverr, tx_off, rx_off, oe_pos, oe_neg, irq;
  line_iface_pkg::line_cond_t want, cond;
  logic [3:0]                 want_level, level_raw;
  logic [7:0]                 rd;
  logic                       err;
  int                         n_errors, checks_done, cycles;
  localparam int CBIT [4] = '{0, 2, 1, 6};

  function automatic logic [15:0] addr(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction

  line_model line_model_i (.clk(clk), .want(want), .want_level(want_level), .cond(cond), .level_raw(level_raw));

  line_iface_status_irq_regs line_iface_status_irq_regs_i (
    .REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SIGNAL_LOST(cond.signal_lost), .RX_SHORT_NOW(cond.rx_short_now), .TX_SHORT_NOW(cond.tx_short_now),
    .TX_OPEN_NOW(cond.tx_open_now), .EQUALIZER_OVER(cond.equalizer_over),
    .EQUALIZER_UNDER(cond.equalizer_under), .JITTER_TRIP(cond.jitter_trip), .RX_LEVEL_RAW(level_raw),
    .DRIVER_OVERRIDE_PIN(pin), .TX_POWER_OFF(tx_off), .RX_POWER_OFF(rx_off),
    .TX_LINE_POS_OE(oe_pos), .TX_LINE_NEG_OE(oe_neg), .LINE_IRQ(irq));

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus tasks: setup, access until ready, then one idle cycle
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd  = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    `CHK(nm, exp, rd)
  endtask

  task automatic settle();
    repeat (5) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pin = 1'b1;
    want = '0;
    want_level = 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("live", addr(line_iface_pkg::IDX_LIVE_COND), 8'h00);
    `CHK("err_ok", 1'b0, err)
    rd_chk("irq_en", addr(line_iface_pkg::IDX_IRQ_ENABLES), 8'h00);
    rd_chk("latch", addr(line_iface_pkg::IDX_EVENT_LATCH), 8'h00);
    `CHK("irq", 1'b0, irq)
    `CHK("ready", 1'b1, pready)
    rd_chk("unmapped", 16'h4100, 8'h00);
    `CHK("err_unmapped", 1'b1, err)
    for (int i = 0; i < 16; i++) begin
      pin <= i[3];
      apb(1'b1, addr(line_iface_pkg::IDX_MAINT_CTRL), 8'(i[2:0]));
      settle();
      `CHK("tx_off", i[2], tx_off)
      `CHK("rx_off", i[1], rx_off)
      `CHK("oe_pos", !i[2] & i[0] & i[3], oe_pos)
      `CHK("oe_neg", !i[2] & i[0] & i[3], oe_neg)
    end
    pin <= 1'b1;
    for (int b = 0; b < 7; b++) begin
      want <= 7'(1 << b);
      settle();
      rd_chk("live_bit", addr(line_iface_pkg::IDX_LIVE_COND), b < 6 ? 8'(1 << b) : 8'h00);
    end
    want <= '0;
    settle();
    apb(1'b1, addr(line_iface_pkg::IDX_LIVE_COND), 8'hff);
    rd_chk("live_ro", addr(line_iface_pkg::IDX_LIVE_COND), 8'h00);
    apb(1'b1, addr(line_iface_pkg::IDX_EVENT_LATCH), 8'hff);
    apb(1'b1, addr(line_iface_pkg::IDX_IRQ_ENABLES), 8'hff);
    rd_chk("irq_en_rw", addr(line_iface_pkg::IDX_IRQ_ENABLES), 8'hff);
    rd_chk("misaligned", addr(line_iface_pkg::IDX_IRQ_ENABLES) + 16'h0001, 8'h00);
    `CHK("err_misaligned", 1'b1, err)
    apb(1'b1, addr(line_iface_pkg::IDX_IRQ_ENABLES) + 16'h0002, 8'h00);
    rd_chk("irq_en_kept", addr(line_iface_pkg::IDX_IRQ_ENABLES), 8'hff);
    for (int k = 0; k < 4; k++) begin
      want <= 7'(1 << CBIT[k]);
      settle();
      rd_chk("latch_on", addr(line_iface_pkg::IDX_EVENT_LATCH), 8'(1 << k));
      `CHK("irq_on", 1'b1, irq)
      want <= '0;
      settle();
      rd_chk("latch_off", addr(line_iface_pkg::IDX_EVENT_LATCH), 8'(17 << k));
      apb(1'b1, addr(line_iface_pkg::IDX_EVENT_LATCH), 8'(1 << k));
      settle();
      rd_chk("latch_w1c", addr(line_iface_pkg::IDX_EVENT_LATCH), 8'(16 << k));
      apb(1'b1, addr(line_iface_pkg::IDX_IRQ_ENABLES), ~8'(16 << k));
      settle();
      `CHK("irq_masked", 1'b0, irq)
      apb(1'b1, addr(line_iface_pkg::IDX_IRQ_ENABLES), 8'(16 << k));
      settle();
      `CHK("irq_enabled", 1'b1, irq)
      apb(1'b1, addr(line_iface_pkg::IDX_EVENT_LATCH), 8'hff);
      settle();
      `CHK("irq_cleared", 1'b0, irq)
      apb(1'b1, addr(line_iface_pkg::IDX_IRQ_ENABLES), 8'hff);
    end
    // Clear write lands on the same edge as a short onset
    want <= 7'h04;
    repeat (2) @(posedge clk);
    apb(1'b1, addr(line_iface_pkg::IDX_EVENT_LATCH), 8'h02);
    settle();
    rd_chk("set_wins", addr(line_iface_pkg::IDX_EVENT_LATCH), 8'h02);
    want <= '0;
    settle();
    rd_chk("set_wins_end", addr(line_iface_pkg::IDX_EVENT_LATCH), 8'h22);
    apb(1'b1, addr(line_iface_pkg::IDX_EVENT_LATCH), 8'hff);
    apb(1'b1, addr(line_iface_pkg::IDX_LEVEL_CFG), 8'h02);
    for (int s = 4; s < 8; s++) begin
      apb(1'b1, addr(line_iface_pkg::IDX_PULSE_SHAPE), 8'(s));
      want <= 7'h06;
      settle();
      want <= '0;
      settle();
      rd_chk("shape_latch", addr(line_iface_pkg::IDX_EVENT_LATCH), s < 5 ? 8'h66 : 8'h60);
      apb(1'b1, addr(line_iface_pkg::IDX_EVENT_LATCH), 8'hff);
    end
    // CSU shape code without T1 mode keeps the onset bits working
    apb(1'b1, addr(line_iface_pkg::IDX_LEVEL_CFG), 8'h00);
    want <= 7'h06;
    settle();
    want <= '0;
    settle();
    rd_chk("e1_shape_latch", addr(line_iface_pkg::IDX_EVENT_LATCH), 8'h66);
    want_level <= 4'hb;
    apb(1'b1, addr(line_iface_pkg::IDX_LEVEL_CFG), 8'h00);
    settle();
    rd_chk("level", addr(line_iface_pkg::IDX_RX_LEVEL), 8'hb0);
    apb(1'b1, addr(line_iface_pkg::IDX_LEVEL_CFG), 8'h61);
    settle();
    rd_chk("level_cap", addr(line_iface_pkg::IDX_RX_LEVEL), 8'h60);
    want_level <= 4'h3;
    settle();
    rd_chk("level_low", addr(line_iface_pkg::IDX_RX_LEVEL), 8'h30);
    tally_and_finish();
  end
endmodule
`default_nettype wire
